// ==== bench/ssb_bridge_bench.sv ====
// self-checking bench of the serial to parallel bus bridge
`timescale 1ns/1ps
`include "ssb_defs.svh"

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH %0t: got %h want %h", $time, (a), (b)); end end

module ssb_bridge_bench;
    // identifier value is arbitrary
    localparam logic [6:0] TID = 7'h2c;
    localparam logic [7:0] AW  = {TID, 1'b0};
    localparam logic [7:0] AR  = {TID, 1'b1};

    logic        clk, nrst, clk_gate_n, scl, sda, sda_out, sda_oe, m_pull;
    logic        command_strobe, cmd_rw, cmd_data_oe, ready_in;
    logic        bus_busy_out, res_vld;
    logic [4:0]  cmd_reg;
    logic [15:0] cmd_data_out, cmd_data_in, rt_dist, rt_cat, rd_val;
    logic [8:0]  res, sexp;
    logic [21:0] bexp;
    logic [8:0]  sq[$];
    logic [21:0] bq[$];
    int          error_cnt, checks;

    // ==========================================================
    // clock, wire with pull-up, design and partner
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    assign sda = ((sda_oe && !sda_out) || m_pull) ? 1'b0 : 1'b1;

    // the only serial slave enabled on this bus
    ssb_bridge #(.TARGET_IDENTIFIER(TID)) dut_u (
        .clk(clk), .nrst(nrst), .clk_gate_n(clk_gate_n),
        .serial_clock_pin(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .command_strobe(command_strobe),
        .cmd_rw(cmd_rw), .cmd_reg(cmd_reg), .cmd_data_out(cmd_data_out),
        .cmd_data_oe(cmd_data_oe), .cmd_data_in(cmd_data_in),
        .ready_in(ready_in), .realtime_distance_reg(rt_dist),
        .realtime_category_reg(rt_cat), .bus_busy_out(bus_busy_out));

    ssb_serial_master m_u (
        .clk(clk), .sda(sda), .scl(scl), .sda_pull(m_pull),
        .res_vld(res_vld), .res(res));

    // ==========================================================
    // neurons: busy a few cycles after each strobe, wrong data meanwhile
    initial begin
        ready_in = 1'b1;
        cmd_data_in = 16'hffff;
        forever begin
            @(posedge clk);
            if (command_strobe === 1'b1) begin
                #1 ready_in = 1'b0;
                cmd_data_in = ~rd_val;
                repeat (3) @(posedge clk);
                #1 ready_in = 1'b1;
                cmd_data_in = rd_val;
                @(posedge clk);
                #1 cmd_data_in = 16'hffff; // released lines float high
            end
        end
    end

    // bus monitor: the neurons sample while the strobe is high
    always @(posedge clk) begin
        if (command_strobe === 1'b1) begin
            `CHK(bq.size() > 0, 1'b1)
            if (bq.size() > 0) begin
                bexp = bq.pop_front();
                `CHK({cmd_rw, cmd_reg}, bexp[21:16])
                `CHK(cmd_data_oe, ~bexp[21])
                if (!bexp[21]) `CHK(cmd_data_out, bexp[15:0])
            end
        end
    end

    // serial monitor: each byte and ack against the oldest note
    always @(posedge res_vld) begin
        `CHK(sq.size() > 0, 1'b1)
        if (sq.size() > 0) begin
            sexp = sq.pop_front();
            `CHK(res, sexp)
        end
    end

    // ==========================================================
    // one byte with its expected wire value and ack
    task automatic op(input logic [7:0] tx, input logic ack_out,
                      input logic [8:0] e);
        sq.push_back(e);
        m_u.xfer(tx, ack_out);
    endtask : op

    // next request only once busy is low and ready is high
    task automatic idle();
        for (int n = 0; n < 400 && (bus_busy_out !== 1'b0
                                    || ready_in !== 1'b1); n++) begin
            @(posedge clk);
            #1;
        end
        `CHK(bus_busy_out, 1'b0)
        if (bus_busy_out !== 1'b0) results();
    endtask : idle

    task automatic wr_req(input logic [7:0] r, input logic [15:0] d);
        bq.push_back({1'b0, r[4:0], d});
        m_u.start();
        op(AW, 1'b0, {AW, 1'b1});
        `CHK(bus_busy_out, 1'b1)
        op(r, 1'b0, {r, 1'b1});
        op(d[7:0], 1'b0, {d[7:0], 1'b1});
        op(d[15:8], 1'b0, {d[15:8], 1'b1});
        m_u.stop();
        idle();
    endtask : wr_req

    task automatic rd_req(input logic [7:0] r, input logic [15:0] e,
                          input logic bus);
        if (bus) bq.push_back({1'b1, r[4:0], 16'h0000});
        m_u.start();
        op(AW, 1'b0, {AW, 1'b1});
        op(r, 1'b0, {r, 1'b1});
        m_u.start();
        op(AR, 1'b0, {AR, 1'b1});
        op(8'hff, 1'b1, {e[7:0], 1'b1});
        op(8'hff, 1'b0, {e[15:8], 1'b0});
        m_u.stop();
        idle();
    endtask : rd_req

    task automatic results();
        $display("comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // ==========================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        clk_gate_n = 1'b0;
        rt_dist = 16'h0000;
        rt_cat = 16'h0000;
        rd_val = 16'h0000;
        error_cnt = 0;
        checks = 0;
        void'($urandom(21262));
        repeat (4) @(posedge clk);
        #1 `CHK({sda_oe, command_strobe, bus_busy_out}, 3'b000)
        nrst = 1'b1;
        // a request inside the stretched reset gets no ack
        m_u.w(100);
        m_u.start();
        op(AW, 1'b0, {AW, 1'b0});
        m_u.stop();
        m_u.w(110);
        // writes back to back with reads; last register has high bits set
        for (int k = 0; k < 4; k++) begin
            wr_req((k == 3) ? 8'he3 : 8'($urandom_range(0, 28)),
                   16'($urandom));
            rd_val = 16'($urandom);
            rd_req(8'h05 + 8'(k), rd_val, 1'b1);
        end
        // real-time results come from the ports, no bus command
        rt_dist = 16'($urandom);
        rt_cat = 16'($urandom);
        rd_req({3'h0, `SSB_RT_DIST_REG}, rt_dist, 1'b0);
        rd_req({3'h0, `SSB_RT_CAT_REG}, rt_cat, 1'b0);
        // a fifth byte in a write is refused, the command still goes out
        bq.push_back({1'b0, 5'h0a, 16'hc33c});
        m_u.start();
        op(AW, 1'b0, {AW, 1'b1});
        op(8'h0a, 1'b0, {8'h0a, 1'b1});
        op(8'h3c, 1'b0, {8'h3c, 1'b1});
        op(8'hc3, 1'b0, {8'hc3, 1'b1});
        op(8'h55, 1'b0, {8'h55, 1'b0});
        m_u.stop();
        idle();
        // foreign identifier: no ack, no busy, later bytes ignored
        m_u.start();
        op({TID ^ 7'h01, 1'b0}, 1'b0, {TID ^ 7'h01, 1'b0, 1'b0});
        op(8'h09, 1'b0, {8'h09, 1'b0});
        `CHK(bus_busy_out, 1'b0)
        m_u.stop();
        // gated clock: the frozen core does not answer
        clk_gate_n = 1'b1;
        m_u.start();
        op(AW, 1'b0, {AW, 1'b0});
        m_u.stop();
        clk_gate_n = 1'b0;
        m_u.w(4);
        wr_req(8'h07, 16'h5aa5);
        `CHK(sq.size(), 0)
        `CHK(bq.size(), 0)
        results();
    end
endmodule : ssb_bridge_bench

// ==== bench/ssb_serial_master.sv ====
// two-wire bus master model that drives the bridge's serial port
`timescale 1ns/1ps

module ssb_serial_master (
    // pacing clock of the bench
    input  wire logic       clk,
    // serial wire
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_pull,
    // one result per byte: byte seen on the wire, then ack seen
    output logic            res_vld,
    output logic [8:0]      res
);
    // ==========================================================
    // idle bus: both lines high, clock stands still
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
        res_vld  = 1'b0;
        res      = 9'h000;
    end

    // ==========================================================
    // wait n clocks, then step just past the edge
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w

    // start or repeated start, only the master makes them
    task automatic start();
        sda_pull = 1'b0;
        w(4);            // lets the slave drop its ack before clock rises
        scl = 1'b1;
        w(4);
        sda_pull = 1'b1; // data falls while clock high
        w(4);
        scl = 1'b0;
        w(2);
    endtask : start

    // stop: data rises while clock high
    task automatic stop();
        sda_pull = 1'b1;
        w(4);
        scl = 1'b1;
        w(4);
        sda_pull = 1'b0;
        w(4);
    endtask : stop

    // eight data bits msb first, then the ack clock pulse
    task automatic xfer(input logic [7:0] tx, input logic ack_out);
        logic [8:0] r;
        for (int i = 8; i >= 0; i--) begin
            // data changes two clocks after clock low, never while high
            sda_pull = (i > 0) ? ~tx[i-1] : ack_out;
            w(2);
            scl = 1'b1;
            w(2);
            r[i] = (i > 0) ? sda : ~sda;
            w(2);
            scl = 1'b0;
            w(2);
        end
        res     = r;
        res_vld = 1'b1;
        w(1);
        res_vld = 1'b0;
    endtask : xfer
endmodule : ssb_serial_master

// ==== verilog/ssb_bridge.sv ====
// serial slave to parallel neuron bus bridge
`timescale 1ns/1ps
`include "ssb_defs.svh"

module ssb_bridge #(
    // arbitrary identifier value
    parameter logic [6:0] TARGET_IDENTIFIER = `SSB_TARGET_ID
) (
    // clock, reset and clock gate
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        clk_gate_n,
    // serial link
    input  wire logic        serial_clock_pin,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // parallel neuron bus
    output logic             command_strobe,
    output logic             cmd_rw,
    output logic [4:0]       cmd_reg,
    output logic [15:0]      cmd_data_out,
    output logic             cmd_data_oe,
    input  wire logic [15:0] cmd_data_in,
    input  wire logic        ready_in,
    // real-time recognition results
    input  wire logic [15:0] realtime_distance_reg,
    input  wire logic [15:0] realtime_category_reg,
    // status
    output logic             bus_busy_out
);

    // =========================================================
    // state and line events
    // =========================================================
    ssb_pkg::ssb_state_t q;
    ssb_pkg::ssb_state_t d;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_det;
    logic                stop_det;
    logic                live;
    logic                bus_idle;
    logic                rt_sel;
    logic [15:0]         rt_value;

    // edges seen only on second and third stages [R25]
    assign scl_rise  = q.scl_s2 & ~q.scl_s3;
    assign scl_fall  = ~q.scl_s2 & q.scl_s3;
    assign start_det = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2; // [R16]
    assign stop_det  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2; // [R17]
    // core advances only when clock passes and reset is over
    assign live      = ~q.run_s2 && (q.rst_cnt == 8'h00); // [R22]
    // real-time results come from the ports, never over the bus [R12]
    assign bus_idle  = (q.bus == ssb_pkg::B_IDLE);
    assign rt_sel    = (q.regn[4:0] == `SSB_RT_DIST_REG)
                     | (q.regn[4:0] == `SSB_RT_CAT_REG);
    assign rt_value  = (q.regn[4:0] == `SSB_RT_DIST_REG)
                     ? realtime_distance_reg : realtime_category_reg;

    // =========================================================
    // next state
    // =========================================================
    // oversampling at 40 MHz covers both link rates [R1]
    always_comb begin
        d        = q;
        d.run_s1 = clk_gate_n;
        d.run_s2 = q.run_s1;
        d.scl_s1 = serial_clock_pin; // [R25]
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = sda_in;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;
        if (q.run_s2) begin
            d.strobe = q.strobe; // gated: core frozen [R22]
        end else if (q.rst_cnt != 8'h00) begin
            d.rst_cnt = q.rst_cnt - 8'h01; // stretched reset [R21]
        end else begin
            // parallel command engine
            case (q.bus)
                ssb_pkg::B_WAIT: begin
                    if (ready_in) begin
                        d.bus    = ssb_pkg::B_STROBE; // [R23]
                        d.strobe = 1'b1;
                    end
                end
                ssb_pkg::B_STROBE: begin
                    d.bus    = ssb_pkg::B_GAP;
                    d.strobe = 1'b0;
                end
                ssb_pkg::B_GAP: begin
                    d.bus = ssb_pkg::B_DONE;
                end
                ssb_pkg::B_DONE: begin
                    // ready rises again when the neurons finish
                    if (ready_in) begin
                        d.bus = ssb_pkg::B_IDLE;
                        if (q.cmd_rw) begin
                            d.rdata = cmd_data_in;
                        end
                    end
                end
                default: begin
                    d.bus = ssb_pkg::B_IDLE;
                end
            endcase
            // serial sequence; start and stop win over any phase
            if (start_det) begin
                d.st     = ssb_pkg::ST_RX; // [R16]
                d.cnt    = 4'h0;
                d.bi     = 3'h0;
                d.sda_oe = 1'b0;
            end else if (stop_det) begin
                d.st     = ssb_pkg::ST_IDLE; // [R17] [R14]
                d.act    = 1'b0;
                d.sda_oe = 1'b0;
            end else begin
                case (q.st)
                    ssb_pkg::ST_RX: begin
                        if (scl_rise) begin
                            d.sr  = {q.sr[6:0], q.sda_s2};
                            d.cnt = q.cnt + 4'h1;
                        end else if (scl_fall && q.cnt == `SSB_BITS) begin
                            d.st     = ssb_pkg::ST_RX_ACK;
                            d.sda_oe = 1'b1; // pull low to ack [R5]
                            d.cnt    = 4'h0;
                            d.bi     = q.bi + 3'h1;
                            case (q.bi)
                                3'h0: begin
                                    // identifier plus direction [R2]
                                    if (q.sr[7:1] != TARGET_IDENTIFIER) begin
                                        d.st     = ssb_pkg::ST_IGNORE; // [R3]
                                        d.sda_oe = 1'b0;
                                        d.act    = 1'b0;
                                    end else begin
                                        d.act = 1'b1;
                                        d.rd  = q.sr[0];
                                        if (q.sr[0] & rt_sel) begin
                                            // results bypass the bus [R12]
                                            d.rdata = rt_value;
                                        end else if (q.sr[0] & bus_idle) begin
                                            d.bus = ssb_pkg::B_WAIT; // [R10]
                                            d.cmd_rw = 1'b1; // [R24]
                                        end
                                    end
                                end
                                3'h1: begin
                                    d.regn = q.sr; // [R5]
                                end
                                3'h2: begin
                                    d.wdata[7:0] = q.sr; // low byte [R9]
                                end
                                3'h3: begin
                                    d.wdata[15:8] = q.sr; // high byte [R9]
                                    if (q.bus == ssb_pkg::B_IDLE) begin
                                        d.bus    = ssb_pkg::B_WAIT; // [R10]
                                        d.cmd_rw = 1'b0; // [R24]
                                    end
                                end
                                default: begin
                                    // a third data byte is not taken
                                    d.st     = ssb_pkg::ST_IGNORE;
                                    d.sda_oe = 1'b0;
                                end
                            endcase
                        end
                    end
                    ssb_pkg::ST_RX_ACK: begin
                        if (scl_fall) begin
                            if (q.rd) begin
                                d.st     = ssb_pkg::ST_TX; // low byte [R7]
                                d.sr     = q.rdata[7:0];
                                d.sda_oe = ~q.rdata[7];
                                d.cnt    = 4'h1;
                                d.bi     = 3'h0;
                            end else begin
                                d.st     = ssb_pkg::ST_RX;
                                d.sda_oe = 1'b0;
                            end
                        end
                    end
                    ssb_pkg::ST_TX: begin
                        if (scl_fall) begin
                            if (q.cnt == `SSB_BITS) begin
                                d.st     = ssb_pkg::ST_TX_ACK;
                                d.sda_oe = 1'b0; // release for ack [R18]
                            end else begin
                                d.sr     = {q.sr[6:0], 1'b0};
                                d.sda_oe = ~q.sr[6];
                                d.cnt    = q.cnt + 4'h1;
                            end
                        end
                    end
                    ssb_pkg::ST_TX_ACK: begin
                        if (scl_rise && q.sda_s2) begin
                            d.st  = ssb_pkg::ST_IDLE; // nack ends read [R19]
                            d.act = 1'b0;
                        end else if (scl_fall) begin
                            if (q.bi == 3'h0) begin
                                d.st     = ssb_pkg::ST_TX; // high byte [R7]
                                d.bi     = 3'h1;
                                d.sr     = q.rdata[15:8];
                                d.sda_oe = ~q.rdata[15];
                                d.cnt    = 4'h1;
                            end else begin
                                // only two bytes per register [R9]
                                d.st = ssb_pkg::ST_IGNORE;
                            end
                        end
                    end
                    default: begin
                        d.sda_oe = 1'b0; // idle or ignoring [R14]
                    end
                endcase
            end
            // busy while a matched request or its command runs
            d.busy = d.act | (d.bus != ssb_pkg::B_IDLE); // [R11]
        end
    end

    // =========================================================
    // registers
    // =========================================================
    // rising edge state, constants only under reset [R21]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q         <= '0;
            q.rst_cnt <= `SSB_RST_HOLD;
        end else begin
            q <= d;
        end
    end

    // bus pins move on the falling edge, half a cycle of setup [R23]
    always_ff @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            command_strobe <= 1'b0;
            cmd_rw         <= 1'b0;
            cmd_reg        <= 5'h00;
            cmd_data_out   <= 16'h0000;
            cmd_data_oe    <= 1'b0;
        end else begin
            command_strobe <= q.strobe;
            cmd_rw         <= q.cmd_rw; // [R24]
            cmd_reg        <= q.regn[4:0];
            cmd_data_out   <= q.wdata;
            cmd_data_oe    <= q.strobe & ~q.cmd_rw; // released otherwise
        end
    end

    assign sda_out      = q.sda_o;
    assign sda_oe       = q.sda_oe;
    assign bus_busy_out = q.busy;

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_byte_end(logic [2:0] idx);
        live && !start_det && !stop_det && q.st == ssb_pkg::ST_RX
            && scl_fall && q.cnt == `SSB_BITS && q.bi == idx;
    endsequence

    property p_mismatch;
        s_byte_end(3'h0) ##0 (q.sr[7:1] != TARGET_IDENTIFIER)
            |=> q.st == ssb_pkg::ST_IGNORE && !sda_oe [*2];
    endproperty
    a_mismatch: assert property (p_mismatch) // [R3]
        else $error("mismatched address was not ignored");

    property p_match_ack;
        s_byte_end(3'h0) ##0 (q.sr[7:1] == TARGET_IDENTIFIER)
            |=> sda_oe && !sda_out && bus_busy_out;
    endproperty
    a_match_ack: assert property (p_match_ack) // [R5]
        else $error("matched address not acknowledged");

    property p_write_cmd;
        s_byte_end(3'h3) ##0 (q.bus == ssb_pkg::B_IDLE)
            |=> q.bus == ssb_pkg::B_WAIT && !q.cmd_rw;
    endproperty
    a_write_cmd: assert property (p_write_cmd) // [R9]
        else $error("high byte did not start a write command");

    property p_extra_nack;
        s_byte_end(3'h4) |=> q.st == ssb_pkg::ST_IGNORE && !sda_oe;
    endproperty
    a_extra_nack: assert property (p_extra_nack) // [R9]
        else $error("byte beyond the register was acknowledged");

    property p_start;
        live && start_det |=> q.st == ssb_pkg::ST_RX && q.cnt == 4'h0;
    endproperty
    a_start: assert property (p_start) // [R16]
        else $error("start condition not taken");

    property p_stop;
        live && stop_det && !start_det
            |=> q.st == ssb_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_stop: assert property (p_stop) // [R17]
        else $error("stop condition not taken");

    property p_ack_release;
        q.st == ssb_pkg::ST_TX_ACK |-> !sda_oe;
    endproperty
    a_ack_release: assert property (p_ack_release) // [R18]
        else $error("data line held during master ack");

    property p_nack;
        live && !start_det && !stop_det && q.st == ssb_pkg::ST_TX_ACK
            && scl_rise && q.sda_s2 |=> q.st == ssb_pkg::ST_IDLE;
    endproperty
    a_nack: assert property (p_nack) // [R19]
        else $error("nack did not end the read");

    property p_strobe_rdy;
        $rose(command_strobe) |-> $past(ready_in) ##1 !command_strobe;
    endproperty
    a_strobe_rdy: assert property (p_strobe_rdy) // [R23]
        else $error("strobe without ready or too long");

    property p_rw;
        command_strobe && cmd_data_oe |-> !cmd_rw;
    endproperty
    a_rw: assert property (p_rw) // [R24]
        else $error("data driven during a read command");

    property p_rst_hold;
        q.rst_cnt != 8'h00 |-> q.st == ssb_pkg::ST_IDLE && !bus_busy_out;
    endproperty
    a_rst_hold: assert property (p_rst_hold) // [R21]
        else $error("core active during stretched reset");

    property p_gate;
        q.run_s2 |=> $stable(q.st) && $stable(q.bus);
    endproperty
    a_gate: assert property (p_gate) // [R22]
        else $error("core moved while clock blocked");

    property p_rt_read;
        s_byte_end(3'h0) ##0 (q.sr == {TARGET_IDENTIFIER, 1'b1})
            && q.regn[4:0] == `SSB_RT_DIST_REG
            |=> q.rdata == $past(realtime_distance_reg)
                && q.bus == $past(q.bus);
    endproperty
    a_rt_read: assert property (p_rt_read) // [R12]
        else $error("real-time distance read used the bus");

endmodule : ssb_bridge

// ==== verilog/ssb_defs.svh ====
// constants of the serial slave to parallel bus bridge
// Operation
// R1: serial port runs at standard or fast rate
// R2: address byte: 7-bit identifier plus direction bit
// R3: mismatch ignored, match acknowledged
// R4: master writes register, low byte, high byte
// R5: acknowledge register number and data bytes
// R6: master reads via repeated start, read address
// R7: send register value low byte first
// R8: master acks bytes, ends read with nack
// R9: each register moves as two bytes
// R10: each request becomes a parallel bus command
// R11: bus busy high while request is processed
// R12: real-time results readable any time, bus untouched
// R13: master waits for idle busy and ready
// R14: bus idle when both lines high
// R15: only master makes start and stop
// R16: start is data falling while clock high
// R17: stop is data rising while clock high
// R18: transmitter releases data, receiver pulls ack low
// R19: nack leaves data high, ends read
// R20: only one chained device enables serial slave
// R21: reset stretched 255 cycles, defaults restored
// R22: clock passes only while gate input low
// R23: strobe changes on falling edge, ready high
// R24: read/write low for write, high for read
// R25: lines synchronised, edges found on system clock
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH
`define SSB_TARGET_ID   7'h35
`define SSB_RST_HOLD    8'hff
`define SSB_BITS        4'h8
`define SSB_RT_DIST_REG 5'h1d
`define SSB_RT_CAT_REG  5'h1e
`endif

// ==== verilog/ssb_pkg.sv ====
// types of the serial slave to parallel bus bridge
package ssb_pkg;

    // serial side sequence
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
    } ssb_st_t;

    // parallel bus command engine
    typedef enum logic [2:0] {
        B_IDLE, B_WAIT, B_STROBE, B_GAP, B_DONE
    } ssb_bus_t;

    // rising-edge state of the bridge; the falling-edge bus pin registers are kept apart
    typedef struct packed {
        logic        run_s1;
        logic        run_s2;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_s3;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_s3;
        logic [7:0]  rst_cnt;
        ssb_st_t     st;
        ssb_bus_t    bus;
        logic [3:0]  cnt;
        logic [2:0]  bi;
        logic [7:0]  sr;
        logic        rd;
        logic        act;
        logic [7:0]  regn;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        cmd_rw;
        logic        strobe;
        logic        sda_oe;
        logic        sda_o;
        logic        busy;
    } ssb_state_t;

endpackage : ssb_pkg
